// ---- ptg_pkg.sv ----
// Shared constants and types of the pulse train / width modulation channel.
package ptg_pkg;

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  localparam int PTG_AW = 8;
  localparam logic [7:0] PTG_OFS_CTRL = 8'h00;
  localparam logic [7:0] PTG_OFS_CYCLE = 8'h04;
  localparam logic [7:0] PTG_OFS_WIDTH = 8'h08;
  localparam logic [7:0] PTG_OFS_COUNT = 8'h0C;
  localparam logic [7:0] PTG_OFS_CMD = 8'h10;
  localparam logic [7:0] PTG_OFS_STATUS = 8'h14;
  localparam logic [7:0] PTG_OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] PTG_OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] PTG_OFS_TBL_ADDR = 8'h20;
  localparam logic [7:0] PTG_OFS_TBL_DATA = 8'h24;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int PTG_CMD_APPLY_BIT = 0;
  localparam int PTG_ST_IDLE_BIT = 0;
  localparam int PTG_ST_RUN_BIT = 1;
  localparam int PTG_ST_SEG_LSB = 8;
  localparam int PTG_IRQ_DONE_BIT = 0;
  localparam int PTG_IRQ_SEG_BIT = 1;
  localparam int PTG_IRQ_W = 2;
  localparam logic [7:0] PTG_CTRL_RST = 8'h00;
  localparam logic [15:0] PTG_WORD_RST = 16'h0000;
  localparam logic [31:0] PTG_DWORD_RST = 32'h0000_0000;
  localparam logic PTG_IDLE_RST = 1'b1;

  // ----------------------------------------------------------------------
  // Documented control byte values
  // ----------------------------------------------------------------------
  localparam logic [7:0] PTG_CB_PTO_US_CT = 8'h81;
  localparam logic [7:0] PTG_CB_PTO_US_PC = 8'h84;
  localparam logic [7:0] PTG_CB_PTO_US_BOTH = 8'h85;
  localparam logic [7:0] PTG_CB_MULTI_US = 8'hA0;
  localparam logic [7:0] PTG_CB_MULTI_MS = 8'hA8;
  localparam logic [7:0] PTG_CB_PWM_US_W = 8'hD2;
  localparam logic [7:0] PTG_CB_PWM_US_BOTH = 8'hD3;
  localparam logic [7:0] PTG_CB_PWM_MS_W = 8'hDA;
  localparam logic [7:0] PTG_CB_PWM_MS_BOTH = 8'hDB;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int PTG_CLK_NS = 20;
  localparam int PTG_US_NS = 1000;
  localparam int PTG_MS_NS = 1000000;
  localparam int PTG_US_CYC = PTG_US_NS / PTG_CLK_NS;
  localparam int PTG_MS_CYC = PTG_MS_NS / PTG_CLK_NS;
  localparam int PTG_TICK_W = 17;
  localparam logic [15:0] PTG_MIN_CYCLE = 16'h0002;
  localparam int PTG_MAX_SEGS = 255;
  localparam int PTG_TBL_AW = 9;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic mode_pwm;
    logic multi;
    logic sync_upd;
    logic ms_base;
    logic ld_count;
    logic ld_width;
    logic ld_cycle;
  } ptg_ctrl_type;

  typedef struct packed {
    logic [PTG_AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ptg_req_type;

  typedef struct packed {
    logic [15:0] initial_cycle_time;
    logic signed [15:0] delta;
    logic [31:0] count;
  } ptg_seg_type;

endpackage

// ---- ptg_tbl_mem.sv ----
// Profile table memory with one write port and a registered read port.
`timescale 1ns/1ps
module ptg_tbl_mem #(
  parameter int AW = 9,
  parameter int DW = 32
) (
  // Clock
  input wire logic clk_sys,
  // Write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read side
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rd_data_r;

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_r <= mem[rd_addr];
  end

  assign rd_data = rd_data_r;
endmodule

// ---- ptg_gen.sv ----
// Pulse train and width modulation generator with register port.
//
// Notes on behaviour
// R1: Apply with 81/84/85 hex: microsecond train, loads cycle, count or both.
// R2: Apply with D3/DB hex runs width modulation, loads width and cycle.
// R3: Apply with D2/DA hex runs width modulation, loads only a new width.
// R4: A profile holds up to 255 segments: ramp up, steady or ramp down.
// R5: Table: count byte, then per segment initial cycle, signed delta, count.
// R6: A segment starts at its initial cycle, adds delta after every pulse.
// R7: Delta is a whole number of time base units.
// R8: Last pulse cycle equals initial plus delta times count minus one.
// R9: Segment duration: count times (initial plus half delta times count-1).
// R10: Host computes delta from ending and initial cycle over the pulse count minus one.
// R11: Host writes control, cycle, width, then applies to start modulation.
// R12: With width-only control held, host writes width then applies.
// R13: Host holds the output low at start of run before configuring.
// R14: Control byte: three load bits, base, update, segments, mode, enable.
// R15: Apply with A0/A8 hex runs a multi segment profile, loads nothing else.
// R16: Idle flag sets when the train, or the whole profile, completes.
// R17: Segments run in table order, next loaded right after the last pulse.
// R18: Output high half the cycle in train mode, the width in modulation mode.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module ptg_gen #(
  parameter int MS_CYCLES = ptg_pkg::PTG_MS_CYC,
  parameter int TBL_AW = ptg_pkg::PTG_TBL_AW
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire ptg_pkg::ptg_req_type bus_req,
  output logic [31:0] bus_rdata,
  // Pulse output and interrupt
  output logic pulse_output_0,
  output logic irq
);
  import ptg_pkg::*;

  typedef enum logic [2:0] {
    G_IDLE = 3'b001,
    G_WAIT = 3'b010,
    G_RUN = 3'b100
  } ptg_gst_type;

  typedef enum logic [4:0] {
    F_IDLE = 5'b00001,
    F_CNT = 5'b00010,
    F_A = 5'b00100,
    F_B = 5'b01000,
    F_HOLD = 5'b10000
  } ptg_fst_type;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [PTG_AW-1:0] a,
                               input logic [PTG_AW-1:0] ofs);
    return a == ofs;
  endfunction

  // Cycles below two units behave as two units.
  function automatic logic [15:0] eff_cyc(input logic [15:0] c);
    return (c < PTG_MIN_CYCLE) ? PTG_MIN_CYCLE : c;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ptg_gst_type gst_r;
  ptg_fst_type fst_r;
  logic [7:0] ctrl_r;
  logic [15:0] cyc_reg_r, wid_reg_r, ld_cyc_r, ld_wid_r;
  logic [31:0] cnt_reg_r, ld_cnt_r, rdata_r;
  logic act_pwm_r, act_ms_r, act_multi_r, pend_r, idle_r;
  logic [15:0] cur_cycle_r, cur_width_r, unit_cnt_r;
  logic signed [15:0] delta_r;
  logic [31:0] pulses_left_r;
  logic [PTG_TICK_W-1:0] tick_cnt_r;
  logic [TBL_AW-1:0] tbl_addr_r, raddr_r;
  logic [31:0] mem_rdata;
  logic wt_r;
  logic [7:0] seg_total_r, fetched_r, seg_idx_r;
  ptg_seg_type nxt_seg_r;
  logic [PTG_IRQ_W-1:0] irq_stat_r, irq_mask_r;
  logic pulse_out_r, irq_r;
  logic [15:0] seg_init_r;
  logic [31:0] seg_n_r;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  ptg_ctrl_type c;
  assign c = ptg_ctrl_type'(ctrl_r); // R14
  wire wr_cmd = bus_req.wr && hit(bus_req.addr, PTG_OFS_CMD);
  wire apply = wr_cmd && bus_req.wdata[PTG_CMD_APPLY_BIT];
  wire wr_tdata = bus_req.wr && hit(bus_req.addr, PTG_OFS_TBL_DATA);
  wire is_multi = !c.mode_pwm && c.multi;
  wire use_ld = c.enable && !is_multi; // R15
  wire [15:0] nxt_ld_cyc = (use_ld && c.ld_cycle) ? cyc_reg_r : ld_cyc_r;
  wire [15:0] nxt_ld_wid = (use_ld && c.ld_width) ? wid_reg_r : ld_wid_r;
  wire [31:0] nxt_ld_cnt = (use_ld && c.ld_count) ? cnt_reg_r : ld_cnt_r;
  // A time base change always restarts the waveform at once.
  wire pwm_sync = c.sync_upd && gst_r == G_RUN && act_pwm_r &&
                  act_ms_r == c.ms_base;
  wire [PTG_TICK_W-1:0] tick_last = act_ms_r ?
    PTG_TICK_W'(MS_CYCLES - 1) : PTG_TICK_W'(PTG_US_CYC - 1);
  wire unit_tick = tick_cnt_r == tick_last;
  wire [15:0] ecyc = eff_cyc(cur_cycle_r);
  wire per_end = gst_r == G_RUN && unit_tick && unit_cnt_r == ecyc - 16'h0001;
  wire last_pulse = !act_pwm_r && pulses_left_r == 32'h0000_0001;
  wire seg_end = per_end && last_pulse;
  wire seg_rdy = fst_r == F_HOLD;
  wire take_seg = !apply && seg_rdy && act_multi_r &&
                  (gst_r == G_WAIT || seg_end); // R17
  wire wait_empty = !apply && gst_r == G_WAIT && fst_r == F_IDLE;
  // A single train of zero pulses never runs, so it is idle at once.
  wire empty_train = !c.mode_pwm && !is_multi && nxt_ld_cnt == 32'h0000_0000;
  wire ev_done = !apply && ((seg_end && !take_seg) || wait_empty); // R16
  wire hi_now = act_pwm_r ? (unit_cnt_r < cur_width_r)
                          : (unit_cnt_r < (ecyc >> 1)); // R18
  wire [PTG_IRQ_W-1:0] ev = {take_seg, ev_done};
  wire [PTG_IRQ_W-1:0] w1c = (bus_req.wr &&
    hit(bus_req.addr, PTG_OFS_IRQ_STAT)) ? bus_req.wdata[PTG_IRQ_W-1:0] : '0;

  // ----------------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_r <= PTG_CTRL_RST;
      cyc_reg_r <= PTG_WORD_RST;
      wid_reg_r <= PTG_WORD_RST;
      cnt_reg_r <= PTG_DWORD_RST;
      irq_mask_r <= '0;
      tbl_addr_r <= '0;
    end else if (bus_req.wr) begin
      if (hit(bus_req.addr, PTG_OFS_CTRL)) ctrl_r <= bus_req.wdata[7:0];
      if (hit(bus_req.addr, PTG_OFS_CYCLE)) cyc_reg_r <= bus_req.wdata[15:0];
      if (hit(bus_req.addr, PTG_OFS_WIDTH)) wid_reg_r <= bus_req.wdata[15:0];
      if (hit(bus_req.addr, PTG_OFS_COUNT)) cnt_reg_r <= bus_req.wdata;
      if (hit(bus_req.addr, PTG_OFS_IRQ_MASK)) begin
        irq_mask_r <= bus_req.wdata[PTG_IRQ_W-1:0];
      end
      if (hit(bus_req.addr, PTG_OFS_TBL_ADDR)) begin
        tbl_addr_r <= bus_req.wdata[TBL_AW-1:0];
      end
      if (wr_tdata) tbl_addr_r <= tbl_addr_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        PTG_OFS_CTRL: rdata_r <= {24'h00_0000, ctrl_r};
        PTG_OFS_CYCLE: rdata_r <= {16'h0000, cyc_reg_r};
        PTG_OFS_WIDTH: rdata_r <= {16'h0000, wid_reg_r};
        PTG_OFS_COUNT: rdata_r <= cnt_reg_r;
        PTG_OFS_STATUS: rdata_r <= {16'h0000, seg_idx_r, 6'h00,
                                    gst_r != G_IDLE, idle_r};
        PTG_OFS_IRQ_STAT: rdata_r <= 32'(irq_stat_r);
        PTG_OFS_IRQ_MASK: rdata_r <= 32'(irq_mask_r);
        PTG_OFS_TBL_ADDR: rdata_r <= 32'(tbl_addr_r);
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Loaded values
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ld_cyc_r <= PTG_MIN_CYCLE;
      ld_wid_r <= PTG_WORD_RST;
      ld_cnt_r <= PTG_DWORD_RST;
    end else if (apply) begin
      ld_cyc_r <= nxt_ld_cyc; // R1 R2
      ld_wid_r <= nxt_ld_wid; // R2 R3
      ld_cnt_r <= nxt_ld_cnt; // R1
    end
  end

  // ----------------------------------------------------------------------
  // Waveform generator
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gst_r <= G_IDLE;
      act_pwm_r <= 1'b0;
      act_ms_r <= 1'b0;
      act_multi_r <= 1'b0;
      pend_r <= 1'b0;
      cur_cycle_r <= PTG_MIN_CYCLE;
      cur_width_r <= PTG_WORD_RST;
      delta_r <= '0;
      pulses_left_r <= PTG_DWORD_RST;
      unit_cnt_r <= PTG_WORD_RST;
      tick_cnt_r <= '0;
      seg_init_r <= PTG_WORD_RST;
      seg_n_r <= PTG_DWORD_RST;
    end else if (apply) begin
      act_pwm_r <= c.mode_pwm;
      act_ms_r <= c.ms_base; // R14
      act_multi_r <= is_multi;
      pend_r <= c.enable && c.mode_pwm && pwm_sync;
      if (!(c.enable && c.mode_pwm && pwm_sync)) begin
        unit_cnt_r <= PTG_WORD_RST;
        tick_cnt_r <= '0;
        cur_cycle_r <= nxt_ld_cyc;
        cur_width_r <= nxt_ld_wid;
        delta_r <= '0;
        pulses_left_r <= nxt_ld_cnt;
        seg_init_r <= nxt_ld_cyc;
        seg_n_r <= nxt_ld_cnt;
        if (!c.enable) gst_r <= G_IDLE;
        else if (is_multi) gst_r <= G_WAIT; // R15
        else if (c.mode_pwm) gst_r <= G_RUN; // R2 R3
        else gst_r <= (nxt_ld_cnt == 32'h0000_0000) ? G_IDLE : G_RUN; // R1
      end
    end else if (take_seg) begin
      gst_r <= G_RUN; // R17
      cur_cycle_r <= nxt_seg_r.initial_cycle_time; // R6
      delta_r <= nxt_seg_r.delta;
      pulses_left_r <= nxt_seg_r.count;
      seg_init_r <= nxt_seg_r.initial_cycle_time;
      seg_n_r <= nxt_seg_r.count;
      unit_cnt_r <= PTG_WORD_RST;
      tick_cnt_r <= '0;
    end else if (wait_empty) begin
      gst_r <= G_IDLE;
    end else if (gst_r == G_RUN) begin
      tick_cnt_r <= unit_tick ? '0 : tick_cnt_r + 1'b1;
      if (per_end) begin
        unit_cnt_r <= PTG_WORD_RST;
        if (act_pwm_r) begin
          if (pend_r) begin
            cur_cycle_r <= ld_cyc_r;
            cur_width_r <= ld_wid_r;
            pend_r <= 1'b0;
          end
        end else if (last_pulse) begin
          gst_r <= G_IDLE; // R16
        end else begin
          pulses_left_r <= pulses_left_r - 1'b1;
          // Whole units only, so the last pulse lands on init + delta*(n-1).
          cur_cycle_r <= cur_cycle_r + delta_r; // R6 R7 R8 R9
        end
      end else if (unit_tick) begin
        unit_cnt_r <= unit_cnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Profile fetch, one segment ahead of the generator
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fst_r <= F_IDLE;
      raddr_r <= '0;
      wt_r <= 1'b0;
      seg_total_r <= 8'h00;
      fetched_r <= 8'h00;
      seg_idx_r <= 8'h00;
      nxt_seg_r <= '0;
    end else if (apply) begin
      raddr_r <= '0;
      wt_r <= 1'b1;
      fetched_r <= 8'h00;
      seg_idx_r <= 8'h00;
      fst_r <= (c.enable && is_multi) ? F_CNT : F_IDLE;
    end else if (wt_r) begin
      wt_r <= 1'b0;
    end else begin
      unique case (fst_r)
        F_IDLE: ;
        F_CNT: begin
          seg_total_r <= mem_rdata[7:0]; // R4 R5
          raddr_r <= raddr_r + 1'b1;
          wt_r <= 1'b1;
          fst_r <= (mem_rdata[7:0] == 8'h00) ? F_IDLE : F_A;
        end
        F_A: begin
          nxt_seg_r.initial_cycle_time <= mem_rdata[15:0]; // R5
          nxt_seg_r.delta <= mem_rdata[31:16];
          raddr_r <= raddr_r + 1'b1;
          wt_r <= 1'b1;
          fst_r <= F_B;
        end
        F_B: begin
          nxt_seg_r.count <= mem_rdata; // R5
          raddr_r <= raddr_r + 1'b1;
          fetched_r <= fetched_r + 8'h01;
          fst_r <= F_HOLD;
        end
        F_HOLD: begin
          if (take_seg) begin
            seg_idx_r <= fetched_r;
            wt_r <= fetched_r < seg_total_r;
            fst_r <= (fetched_r < seg_total_r) ? F_A : F_IDLE; // R17
          end
        end
      endcase
    end
  end

  ptg_tbl_mem #(.AW(TBL_AW), .DW(32)) u_tbl (
    .clk_sys(clk_sys),
    .wr_en(wr_tdata),
    .wr_addr(tbl_addr_r),
    .wr_data(bus_req.wdata),
    .rd_addr(raddr_r),
    .rd_data(mem_rdata)
  );

  // ----------------------------------------------------------------------
  // Status, interrupt and output
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      idle_r <= PTG_IDLE_RST;
      irq_stat_r <= '0;
      irq_r <= 1'b0;
      pulse_out_r <= 1'b0;
    end else begin
      if (apply) idle_r <= !c.enable || empty_train; // R16
      else if (ev_done) idle_r <= 1'b1; // R16
      // A new event wins over a simultaneous clear.
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
      irq_r <= |(irq_stat_r & irq_mask_r);
      pulse_out_r <= gst_r == G_RUN && !apply && hi_now; // R18
    end
  end

  assign bus_rdata = rdata_r;
  assign pulse_output_0 = pulse_out_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_apply(logic [7:0] v);
    apply && ctrl_r == v;
  endsequence

  property p_pto_both;
    s_apply(PTG_CB_PTO_US_BOTH) ##0 (cnt_reg_r != 32'h0000_0000) |=>
      gst_r == G_RUN && !act_ms_r && ld_cyc_r == $past(cyc_reg_r) &&
      pulses_left_r == $past(cnt_reg_r);
  endproperty
  a_pto_both: assert property (p_pto_both) // R1
    else $error("single train did not load cycle and count");

  property p_pto_ct_only;
    s_apply(PTG_CB_PTO_US_CT) |=> ld_cnt_r == $past(ld_cnt_r);
  endproperty
  a_pto_ct_only: assert property (p_pto_ct_only) // R1
    else $error("cycle-only apply changed the pulse count");

  property p_pwm_both;
    s_apply(PTG_CB_PWM_MS_BOTH) |=> act_pwm_r && act_ms_r &&
      ld_cyc_r == $past(cyc_reg_r) && ld_wid_r == $past(wid_reg_r);
  endproperty
  a_pwm_both: assert property (p_pwm_both) // R2
    else $error("modulation apply did not load width and cycle");

  property p_pwm_width;
    s_apply(PTG_CB_PWM_US_W) |=> ld_cyc_r == $past(ld_cyc_r) &&
      ld_wid_r == $past(wid_reg_r) && gst_r == G_RUN;
  endproperty
  a_pwm_width: assert property (p_pwm_width) // R3
    else $error("width-only apply loaded wrong values");

  property p_multi;
    s_apply(PTG_CB_MULTI_US) |=> gst_r == G_WAIT && fst_r == F_CNT &&
      ld_cyc_r == $past(ld_cyc_r) && ld_cnt_r == $past(ld_cnt_r);
  endproperty
  a_multi: assert property (p_multi) // R15
    else $error("profile apply did not start the table fetch");

  property p_delta_step;
    per_end && !act_pwm_r && !last_pulse && !apply && !take_seg |=>
      cur_cycle_r == $past(cur_cycle_r) + $past(delta_r) &&
      pulses_left_r == $past(pulses_left_r) - 32'h0000_0001;
  endproperty
  a_delta_step: assert property (p_delta_step) // R6
    else $error("cycle time did not step by delta");

  property p_last_cycle;
    seg_end |-> cur_cycle_r ==
      16'(seg_init_r + delta_r * 16'(seg_n_r - 32'h0000_0001));
  endproperty
  a_last_cycle: assert property (p_last_cycle) // R8
    else $error("last pulse cycle time is wrong");

  property p_chain;
    seg_end && take_seg |=> gst_r == G_RUN &&
      cur_cycle_r == $past(nxt_seg_r.initial_cycle_time) && unit_cnt_r == 16'h0000;
  endproperty
  a_chain: assert property (p_chain) // R17
    else $error("next segment did not follow without a gap");

  property p_done;
    ev_done |=> idle_r ##1 (irq_stat_r[PTG_IRQ_DONE_BIT] || $past(w1c[0]));
  endproperty
  a_done: assert property (p_done) // R16
    else $error("completion did not set idle and its status bit");

  property p_half_high;
    gst_r == G_RUN && !act_pwm_r && !apply && unit_cnt_r >= (ecyc >> 1) |=>
      !pulse_out_r;
  endproperty
  a_half_high: assert property (p_half_high) // R18
    else $error("train output high past half the cycle");

endmodule

// ---- ptg_load_model.sv ----
// Behavioural load on the pulse output that measures every pulse it sees.
`timescale 1ns/1ps
module ptg_load_model (
  // Clock
  input wire logic clk_sys,
  // Pulse line from the generator
  input wire logic pulse_in,
  // Measurements in clock cycles
  output logic [31:0] n_pulses,
  output logic [31:0] high_len,
  output logic [31:0] period_len
);
  logic prev_r;
  logic [31:0] hi_r;
  logic [31:0] per_r;
  // A period is only known at the next rising edge, so the last period
  // of a train is never reported.
  initial begin
    prev_r = 1'b0;
    hi_r = 0;
    per_r = 0;
    n_pulses = 0;
    high_len = 0;
    period_len = 0;
  end
  always @(posedge clk_sys) begin
    prev_r <= pulse_in;
    if (pulse_in && !prev_r) begin
      n_pulses <= n_pulses + 1;
      period_len <= per_r;
      per_r <= 1;
      hi_r <= 1;
    end else begin
      per_r <= per_r + 1;
      if (pulse_in) hi_r <= hi_r + 1;
    end
    if (!pulse_in && prev_r) high_len <= hi_r;
  end
endmodule

// ---- tb.sv ----
// Self-checking bench of the pulse generator channel.
`timescale 1ns/1ps
module tb;
  import ptg_pkg::*;
  localparam int MSC = 10;
  localparam int US = PTG_US_CYC;
  logic clk_sys;
  logic sys_rst;
  ptg_req_type bus_req;
  logic [31:0] bus_rdata;
  logic pulse_output_0;
  logic irq;
  logic [31:0] n_pulses;
  logic [31:0] high_len;
  logic [31:0] period_len;
  logic [31:0] rv;
  int n_errors;
  int comparisons;
  int cyc;
  int t0;
  int t1;
  ptg_gen #(.MS_CYCLES(MSC), .TBL_AW(PTG_TBL_AW)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .pulse_output_0(pulse_output_0), .irq(irq));
  ptg_load_model load (.clk_sys(clk_sys), .pulse_in(pulse_output_0),
    .n_pulses(n_pulses), .high_len(high_len), .period_len(period_len));
  // ----------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end
  task complete_run;
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ----------------------------------------------------------------
  // Register port and waits
  // ----------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 rv = bus_rdata;
  endtask
  task wait_n(input logic [31:0] n);
    int k;
    k = 0;
    while (n_pulses < n && k < 5000) begin
      @(posedge clk_sys);
      #1 k++;
    end
    t1 = cyc;
    chk("pulse count", n, n_pulses);
  endtask
  // Polling keeps the wait bounded even if idle never returns.
  task wait_idle;
    int k;
    k = 0;
    rd(PTG_OFS_STATUS);
    while (rv[0] !== 1'b1 && k < 300) begin
      rd(PTG_OFS_STATUS);
      k++;
    end
    chk("status idle", 32'h1, rv & 32'h3);
  endtask
  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  task apply(input logic [7:0] cb);
    wr(PTG_OFS_CTRL, {24'h0, cb});
    wr(PTG_OFS_CMD, 32'h1);
  endtask
  task pulse_train_mode(input logic [7:0] cb, input int n, input int c);
    int b;
    b = n_pulses;
    apply(cb);
    wait_n(b + n);
    wait_idle();
    chk("train period", c * US, period_len);
    chk("train high", c * US / 2, high_len);
  endtask
  task prof(input logic [7:0] cb, input int u);
    int b;
    b = n_pulses;
    apply(cb);
    wait_n(b + 1);
    t0 = t1;
    wait_n(b + 2);
    chk("first period", 4 * u, period_len);
    wait_n(b + 3);
    chk("seg0 duration", 10 * u, 32'(t1 - t0));
    chk("seg0 last period", 6 * u, period_len);
    rd(PTG_OFS_STATUS);
    chk("segment in progress", 32'h0000_0202, rv & 32'h0000_FF03);
    wait_idle();
    chk("seg1 high", 2 * u, high_len);
  endtask
  task pwm(input logic [7:0] cb, input int u, input int w, input int c);
    apply(cb);
    wait_n(n_pulses + 3);
    chk("pwm high", w * u, high_len);
    chk("pwm period", c * u, period_len);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc = 0;
    n_errors = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    bus_req = '0;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1 chk("output at start", 32'h0, {31'h0, pulse_output_0});
    rd(PTG_OFS_STATUS);
    chk("status reset", 32'h1, rv & 32'h3);
    rd(8'h3C);
    chk("unmapped read", 32'h0, rv);
    wr(PTG_OFS_IRQ_MASK, 32'h1);
    wr(PTG_OFS_CYCLE, 32'h4);
    wr(PTG_OFS_COUNT, 32'h2);
    pulse_train_mode(PTG_CB_PTO_US_BOTH, 2, 4);
    @(posedge clk_sys);
    #1 chk("irq done", 32'h1, {31'h0, irq});
    wr(PTG_OFS_IRQ_STAT, 32'h3);
    rd(PTG_OFS_IRQ_STAT);
    chk("irq cleared", 32'h0, rv);
    wr(PTG_OFS_CYCLE, 32'h2);
    pulse_train_mode(PTG_CB_PTO_US_CT, 2, 2);
    wr(PTG_OFS_COUNT, 32'h3);
    wr(PTG_OFS_CYCLE, 32'h6);
    pulse_train_mode(PTG_CB_PTO_US_PC, 3, 2);
    wr(PTG_OFS_COUNT, 32'h0);
    apply(PTG_CB_PTO_US_PC);
    wait_idle();
    wr(PTG_OFS_IRQ_STAT, 32'h3);
    wr(PTG_OFS_IRQ_MASK, 32'h0);
    // Host-side ramp: delta 2 takes the cycle from 4 up to 6 units.
    wr(PTG_OFS_TBL_ADDR, 32'h0);
    wr(PTG_OFS_TBL_DATA, 32'h2);
    wr(PTG_OFS_TBL_DATA, 32'h0002_0004);
    wr(PTG_OFS_TBL_DATA, 32'h2);
    wr(PTG_OFS_TBL_DATA, 32'h4);
    wr(PTG_OFS_TBL_DATA, 32'h1);
    prof(PTG_CB_MULTI_US, US);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(PTG_OFS_IRQ_STAT);
    chk("irq status", 32'h3, rv);
    wr(PTG_OFS_IRQ_MASK, 32'h3);
    @(posedge clk_sys);
    #1 chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(PTG_OFS_IRQ_STAT, 32'h3);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq after clear", 32'h0, {31'h0, irq});
    prof(PTG_CB_MULTI_MS, MSC);
    wr(PTG_OFS_CYCLE, 32'h4);
    wr(PTG_OFS_WIDTH, 32'h1);
    pwm(PTG_CB_PWM_US_BOTH, US, 1, 4);
    wr(PTG_OFS_CYCLE, 32'h8);
    wr(PTG_OFS_WIDTH, 32'h3);
    pwm(PTG_CB_PWM_US_W, US, 3, 4);
    wr(PTG_OFS_CYCLE, 32'h4);
    wr(PTG_OFS_WIDTH, 32'h1);
    pwm(PTG_CB_PWM_MS_BOTH, MSC, 1, 4);
    wr(PTG_OFS_CYCLE, 32'h8);
    wr(PTG_OFS_WIDTH, 32'h2);
    pwm(PTG_CB_PWM_MS_W, MSC, 2, 4);
    apply(8'h0);
    wait_idle();
    repeat (3) @(posedge clk_sys);
    #1 chk("output disabled", 32'h0, {31'h0, pulse_output_0});
    complete_run();
  end
endmodule
